/* File: verif/host_model.sv */
// Host front end model: decoded register writes and reads with a write-busy window.
// Assumes requests change on the falling edge and the design samples on the rising edge.
module host_model
   import monitor_pkg::*;
(
   input wire logic              core_clk,
   output monitor_pkg::reg_req_t regReq,
   output logic                  wrBusy,
   input wire logic [15:0]       regRdData
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Idle request at time zero.
   initial begin
      regReq = '0;
      wrBusy = 1'b0;
   end

   // Busy covers one edge past the strobe; released data is inverted so it is never stale.
   task automatic write_reg(input logic [7:0] a, input logic [15:0] d);
      @(negedge core_clk);
      regReq = '{wrEn: 1'b1, rdEn: 1'b0, addr: a, wrData: d};
      wrBusy = 1'b1;
      @(negedge core_clk);
      regReq.wrEn = 1'b0;
      regReq.wrData = ~d;
      @(negedge core_clk);
      wrBusy = 1'b0;
   endtask

   // Read data is registered at the edge that takes the strobe.
   task automatic read_reg(input logic [7:0] a, output logic [15:0] d);
      @(negedge core_clk);
      regReq.rdEn = 1'b1;
      regReq.addr = a;
      @(negedge core_clk);
      regReq.rdEn = 1'b0;
      d = regRdData;
   endtask
endmodule

/* File: verif/monitor_measurement_config_monitor.sv */
// Concurrent checks on the ports of the monitor measurement and configuration block.
// Assumes one core clock and a synchronous active-high reset; bound to the design below.
module monitor_measurement_config_monitor
   import monitor_pkg::*;
(
   input wire logic                  core_clk,
   input wire logic                  rst,
   input wire monitor_pkg::reg_req_t regReq,
   input wire logic                  wrBusy,
   input wire logic [15:0]           regRdData,
   input wire logic                  sampleReady,
   input wire logic signed [15:0]    shuntSample,
   input wire logic                  measuring,
   input wire logic                  measuringCurrent,
   input wire logic                  poweredDown
);
   timeunit 1ns;
   timeprecision 1ps;
   import monitor_pkg::*;
   // ==========================================================
   // Mirror of the writable fields.
   logic [11:0] cfgFf;
   logic [11:0] nxt_cfg;
   logic        softFf;
   logic        nxt_soft;

   // A soft reset may land one edge late, so that edge is not judged.
   always_comb begin
      nxt_cfg = cfgFf;
      nxt_soft = 1'b0;
      if (regReq.wrEn && regReq.addr == CFG_ADDR) begin
         nxt_cfg = regReq.wrData[15] ? CFG_RESET[11:0] : regReq.wrData[11:0];
         nxt_soft = regReq.wrData[15];
      end
      if (rst) begin
         nxt_cfg = CFG_RESET[11:0];
         nxt_soft = 1'b0;
      end
   end

   // Mirror registers.
   always_ff @(posedge core_clk) begin
      cfgFf <= nxt_cfg;
      softFf <= nxt_soft;
   end

   // ==========================================================
   // Properties.
   default clocking @(posedge core_clk); endclocking
   default disable iff (rst);
   sequence s_cfg_wr;
      regReq.wrEn && regReq.addr == CFG_ADDR;
   endsequence
   sequence s_cfg_rd;
      regReq.rdEn && !regReq.wrEn && regReq.addr == CFG_ADDR && !softFf;
   endsequence
   property p_pd; !softFf |-> poweredDown == (cfgFf[1:0] == 2'b00); endproperty
   property p_pd_idle; poweredDown |-> !measuring; endproperty
   property p_cur; measuringCurrent |-> measuring && cfgFf[MODE_CUR_BIT]; endproperty
   property p_halt; s_cfg_wr |=> !measuring; endproperty
   property p_busy; wrBusy && !measuring |=> !measuring; endproperty
   property p_start; $fell(rst) && !regReq.wrEn && !wrBusy |=> measuringCurrent; endproperty
   property p_rstval; $fell(rst) |-> regRdData == CUR_RESET && !measuring; endproperty
   property p_rdcfg; s_cfg_rd |=> regRdData == {1'b0, CFG_FIXED, cfgFf}; endproperty
   property p_unmapped; regReq.rdEn && regReq.addr > CUR_ADDR |=> regRdData == RD_UNMAPPED; endproperty
   property p_rdcont; s_cfg_rd ##0 (measuring && !wrBusy && cfgFf[MODE_CONT_BIT]) |=> measuring; endproperty
   a_pd: assert property (p_pd) else $error("power-down flag disagrees with mode");
   a_pd_idle: assert property (p_pd_idle) else $error("conversion while powered down");
   a_cur: assert property (p_cur) else $error("current conversion not enabled by mode");
   a_halt: assert property (p_halt) else $error("conversion not halted by write");
   a_busy: assert property (p_busy) else $error("conversion started during write");
   a_start: assert property (p_start) else $error("no current conversion after reset");
   a_rstval: assert property (p_rstval) else $error("bad state after reset");
   a_rdcfg: assert property (p_rdcfg) else $error("configuration readback wrong");
   a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
   a_rdcont: assert property (p_rdcont) else $error("read disturbed conversion");
endmodule

bind monitor_measurement_config monitor_measurement_config_monitor u_monitor (
   .core_clk(core_clk), .rst(rst), .regReq(regReq), .wrBusy(wrBusy), .regRdData(regRdData),
   .sampleReady(sampleReady), .shuntSample(shuntSample), .measuring(measuring),
   .measuringCurrent(measuringCurrent), .poweredDown(poweredDown));

/* File: verif/monitor_measurement_config_test.sv */
// Self-checking bench for the monitor measurement and configuration block.
// Assumes the host model and the bound checker are compiled alongside.
module monitor_measurement_config_test;
   timeunit 1ns;
   timeprecision 1ps;
   import monitor_pkg::*;
   typedef struct packed {logic [15:0] wr; logic [15:0] rd; logic pd;} row_t;
   // Each row sets every field code once; bits 14..12 are written as ones on purpose.
   localparam row_t ROWS [8] = '{'{16'h7038, 16'h6038, 1'b1}, '{16'h7271, 16'h6271, 1'b0},
      '{16'h74aa, 16'h64aa, 1'b0}, '{16'h76e3, 16'h66e3, 1'b0}, '{16'h791c, 16'h691c, 1'b1},
      '{16'h7b55, 16'h6b55, 1'b0}, '{16'h7d8e, 16'h6d8e, 1'b0}, '{16'h7fc7, 16'h6fc7, 1'b0}};
   // Any four consecutive samples sum to -6, so the floored mean is -2 whatever the alignment.
   localparam logic signed [15:0] SAMPLES [4] = '{-16'sd8, -16'sd2, 16'sd5, -16'sd1};
   // Shortened conversion table indexed by time code, and sample counts of averaging codes 0 to 3.
   localparam int unsigned CONV_T [8] = '{4, 5, 6, 7, 8, 9, 10, 11};
   localparam int unsigned AVG_N [4]  = '{1, 4, 16, 64};
   logic                  core_clk = 1'b0;
   logic                  rst = 1'b1;
   logic                  sampleReady = 1'b0;
   logic                  wasCur = 1'b0;
   logic signed [15:0]    shuntSample = '0;
   logic [15:0]           regRdData;
   logic [15:0]           rd;
   logic                  wrBusy;
   logic                  measuring;
   logic                  measuringCurrent;
   logic                  poweredDown;
   monitor_pkg::reg_req_t regReq;
   int                    n_errors = 0;
   int                    compares = 0;
   int                    idx = 0;
   int                    nRun = 0;
   int                    nCur = 0;

   always #10 core_clk = ~core_clk;

   host_model host (.core_clk(core_clk), .regReq(regReq), .wrBusy(wrBusy), .regRdData(regRdData));
   monitor_measurement_config #(.CONV_CYCLES(CONV_T)) DUT (
      .core_clk(core_clk), .rst(rst), .regReq(regReq), .wrBusy(wrBusy), .regRdData(regRdData),
      .sampleReady(sampleReady), .shuntSample(shuntSample), .measuring(measuring),
      .measuringCurrent(measuringCurrent), .poweredDown(poweredDown));

   // ==========================================================
   // Converter stand-in: next sample each time measuringCurrent falls, ready only every other cycle.
   always @(negedge core_clk) begin
      if (wasCur && !measuringCurrent) idx = (idx + 1) % 4;
      wasCur = measuringCurrent;
      shuntSample = SAMPLES[idx];
      sampleReady = ~sampleReady;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         n_errors++;
         $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
      end
   endtask

   // Writes a setting, then counts the busy cycles of the sequence it starts; bounded so
   // a sequencer that never goes idle shows up as a wrong count instead of a hang.
   task automatic time_run(input logic [15:0] cfg);
      host.write_reg(CFG_ADDR, cfg);
      nRun = 0;
      nCur = 0;
      @(negedge core_clk);
      while (measuring && nRun < 1000) begin
         nRun++;
         if (measuringCurrent) nCur++;
         @(negedge core_clk);
      end
   endtask

   task automatic stop_test;
      $display("errors %0d compares %0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask

   // ==========================================================
   // Main sequence.
   initial begin
      repeat (6) @(negedge core_clk);
      rst = 1'b0;
      host.read_reg(CUR_ADDR, rd);
      check(rd, CUR_RESET);
      host.read_reg(CFG_ADDR, rd);
      check(rd, CFG_RESET);
      host.read_reg(8'h02, rd);
      check(rd, RD_UNMAPPED);
      foreach (ROWS[i]) begin
         host.write_reg(CFG_ADDR, ROWS[i].wr);
         host.read_reg(CFG_ADDR, rd);
         check(rd, ROWS[i].rd);
         check({15'h0000, poweredDown}, {15'h0000, ROWS[i].pd});
         check({15'h0000, measuring}, {15'h0000, !ROWS[i].pd});
      end
      // Four-sample average of mixed-sign readings with a negative mean, then a write to the read-only result.
      host.write_reg(CFG_ADDR, 16'h0207);
      repeat (150) @(negedge core_clk);
      host.write_reg(CUR_ADDR, 16'hffff);
      host.read_reg(CUR_ADDR, rd);
      check(rd, 16'hfffe);
      host.read_reg(CFG_ADDR, rd);
      check(rd, 16'h6207);
      check({15'h0000, measuring}, 16'h0001);
      // Triggered mode runs once and idles until the next write.
      host.write_reg(CFG_ADDR, 16'h0003);
      repeat (60) @(negedge core_clk);
      check({15'h0000, measuring}, 16'h0000);
      host.write_reg(CFG_ADDR, 16'h0003);
      host.read_reg(CFG_ADDR, rd);
      check({15'h0000, measuring}, 16'h0001);
      // Bus-only triggered runs: one conversion lasts exactly its table entry.
      for (int c = 0; c < 8; c++) begin
         time_run(16'h0002 | 16'(c << 6));
         check(16'(nRun), 16'(CONV_T[c]));
         check(16'(nCur), 16'h0000);
      end
      // Current-only triggered runs: the converter may add one cycle of ready wait.
      for (int c = 0; c < 8; c++) begin
         time_run(16'h0001 | 16'(c << 3));
         check({15'h0000, (nRun - CONV_T[c]) <= 1}, 16'h0001);
         check(16'(nCur), 16'(nRun));
      end
      // A triggered set is as many conversions as the averaging code asks for.
      for (int a = 0; a < 4; a++) begin
         time_run(16'h0002 | 16'(a << 9));
         check(16'(nRun), 16'(AVG_N[a] * CONV_T[0]));
      end
      host.write_reg(CFG_ADDR, 16'h8000);
      host.read_reg(CFG_ADDR, rd);
      check(rd, CFG_RESET);
      host.read_reg(CUR_ADDR, rd);
      check(rd, CUR_RESET);
      stop_test();
   end

   // The whole run takes about a thousand cycles; the limit allows five times that.
   initial begin
      #100000;
      n_errors++;
      stop_test();
   end
endmodule

/* File: verilog/monitor_measurement_config.sv */
// Configuration register, conversion sequencer and signed current result register.
// Assumes the serial front end decodes transfers into a pointer-addressed register port
// and holds wrBusy high while a write transfer is in flight; converter samples arrive
// on the same clock.
// Limitations: only the current result is stored here. Bus-voltage conversions are timed
// so that the measurement cadence is right, but their samples are not kept by this block.
// The conversion time table is a parameter, so that a bench can shorten it; the default
// holds the full times counted in core clock cycles.
// Power-down modes leave the sequencer idle; the result register keeps its last value.
//
// Operation
// R1: Writing one to configuration bit 15 resets all registers; the bit reads zero.
// R2: Bits 11..9 pick averaging 1,4,16,64,128,256,512,1024; default 000.
// R3: Bits 8..6 pick bus conversion time 140 us to 8.244 ms; default 100.
// R4: Bits 5..3 pick current conversion time, same table; default 100.
// R5: Mode 000/100 power-down, 001-011 triggered, 101-111 continuous; current, bus, both.
// R6: Mode resets to 111, continuous current and bus measurement.
// R7: Current result is signed 16-bit, 1.25 mA per bit, read-only, resets zero.
// R8: With averaging above one, result register takes the mean of the samples.
// R9: A configuration write halts conversion until transfer ends, then restarts fresh.
// R10: Reading the configuration register changes no setting nor running conversion.
// R11: Triggered mode runs one averaged sequence per write, then idles.
module monitor_measurement_config
   import monitor_pkg::*;
#(
   parameter int unsigned CONV_CYCLES [8] = monitor_pkg::CONV_CYCLES_DEF
) (
   input  wire logic                   core_clk,
   input  wire logic                   rst,
   input  wire monitor_pkg::reg_req_t  regReq,
   input  wire logic                   wrBusy,
   output logic [15:0]                 regRdData,
   input  wire logic                   sampleReady,
   input  wire logic signed [15:0]     shuntSample,
   output logic                        measuring,
   output logic                        measuringCurrent,
   output logic                        poweredDown
);
   import monitor_pkg::*;

   // Stored state: settings, result, read data, sequencer and its counters.
   cfg_t                 cfg_ff,   nxt_cfg;
   logic signed [15:0]   cur_ff,   nxt_cur;
   logic [15:0]          rd_ff,    nxt_rd;
   seq_state_t           state_ff, nxt_state;
   logic [TIMER_W-1:0]   timer_ff, nxt_timer;
   logic [AVG_MAX_LOG2:0] set_ff,  nxt_set;
   // Decoded controls and the averager handshake.
   logic                 softReset;
   logic                 cfgWrite;
   logic                 modeCur, modeBus, modeCont, modeOff;
   logic                 timerDone;
   logic                 avgClear;
   logic                 curSampleValid;
   logic                 avgValid;
   logic signed [15:0]   avgResult;
   logic [AVG_MAX_LOG2:0] setLast;

   // ==========================================================
   // Mode decode and write qualification.
   // Only pointer zero is writable; writes to any other pointer change nothing, but
   // the transfer still halts conversion through wrBusy.
   assign cfgWrite  = regReq.wrEn && (regReq.addr == CFG_ADDR);
   assign softReset = cfgWrite && regReq.wrData[15];                              // R1
   assign modeCur   = cfg_ff.opMode[MODE_CUR_BIT];                                // R5
   assign modeBus   = cfg_ff.opMode[MODE_BUS_BIT];
   assign modeCont  = cfg_ff.opMode[MODE_CONT_BIT];
   assign modeOff   = !modeCur && !modeBus;
   assign timerDone = (timer_ff == '0);
   assign setLast   = (AVG_MAX_LOG2+1)'((1 << AVG_LOG2[cfg_ff.sampleAverageCount]) - 1); // R2
   assign curSampleValid = (state_ff == ST_CONVCUR) && timerDone && sampleReady;
   assign avgClear  = cfgWrite || wrBusy || softReset;

   // ==========================================================
   // Register file: configuration write, read data capture, result load.
   // Reads only capture data, so a read never disturbs settings or the sequencer.
   // A read in the same cycle as a write, other than a full-reset write, returns the old
   // contents, because the read data is taken from the stored register and not from the incoming write.
   // A result that lands while a write is halting conversion is dropped, since it was
   // gathered under settings that are being replaced.
   always_comb begin
      nxt_cfg = cfg_ff;
      nxt_cur = cur_ff;
      nxt_rd  = rd_ff;
      if (cfgWrite) begin
         nxt_cfg           = cfg_t'(regReq.wrData);
         nxt_cfg.fullReset = 1'b0;                                                // R1
         nxt_cfg.fixedBits = CFG_FIXED;
      end
      if (avgValid && !avgClear) begin
         nxt_cur = avgResult;                                                     // R8
      end
      if (regReq.rdEn) begin
         case (regReq.addr)                                                       // R10
            CFG_ADDR: nxt_rd = 16'(cfg_ff);
            CUR_ADDR: nxt_rd = 16'(cur_ff);                                       // R7
            default:  nxt_rd = RD_UNMAPPED;
         endcase
      end
   end

   // ==========================================================
   // Sequencer: halt during writes, then convert current and/or bus per sample.
   // Each sample is a current conversion when the mode asks for one, which ends only when the
   // converter has a value ready, followed by a bus conversion when the mode asks for one. The set counter
   // counts samples; when it reaches the averaging count a triggered mode goes idle
   // and a continuous mode wraps round and starts the next set.
   // The timer is loaded with one less than the conversion length, so that a
   // bus conversion occupies exactly the number of cycles in the table and a current one that many plus any ready wait.
   always_comb begin
      nxt_state = state_ff;
      nxt_timer = timer_ff;
      nxt_set   = set_ff;
      case (state_ff)
         // Waits for the write transfer to finish before starting fresh.
         ST_HALT: begin
            nxt_set = '0;
            if (!wrBusy && !cfgWrite) begin                                       // R9
               // Power-down modes go straight to idle.
               if (modeOff) begin
                  nxt_state = ST_IDLE;
               end else if (modeCur) begin
                  nxt_state = ST_CONVCUR;
                  nxt_timer = TIMER_W'(CONV_CYCLES[cfg_ff.shuntCurrentConvTime] - 1); // R4
               end else begin
                  nxt_state = ST_CONVBUS;
                  nxt_timer = TIMER_W'(CONV_CYCLES[cfg_ff.busVoltageConvTime] - 1);   // R3
               end
            end
         end
         // Results are held; only a write wakes the sequencer again.
         ST_IDLE: begin
            nxt_set = '0;                                                         // R11
         end
         // Count down, then wait for the converter before taking the sample.
         ST_CONVCUR: begin
            if (!timerDone) begin
               nxt_timer = timer_ff - 1'b1;
            end else if (sampleReady) begin
               if (modeBus) begin
                  nxt_state = ST_CONVBUS;
                  nxt_timer = TIMER_W'(CONV_CYCLES[cfg_ff.busVoltageConvTime] - 1); // R3
               end else if (set_ff == setLast && !modeCont) begin
                  nxt_state = ST_IDLE;                                            // R11
               end else begin
                  nxt_set   = (set_ff == setLast) ? '0 : set_ff + 1'b1;
                  nxt_timer = TIMER_W'(CONV_CYCLES[cfg_ff.shuntCurrentConvTime] - 1); // R4
               end
            end
         end
         // The bus conversion closes the sample when both quantities are measured.
         ST_CONVBUS: begin
            if (!timerDone) begin
               nxt_timer = timer_ff - 1'b1;
            end else if (set_ff == setLast && !modeCont) begin
               nxt_state = ST_IDLE;                                               // R11
            end else begin
               nxt_set = (set_ff == setLast) ? '0 : set_ff + 1'b1;                // R5
               if (modeCur) begin
                  nxt_state = ST_CONVCUR;
                  nxt_timer = TIMER_W'(CONV_CYCLES[cfg_ff.shuntCurrentConvTime] - 1);
               end else begin
                  nxt_timer = TIMER_W'(CONV_CYCLES[cfg_ff.busVoltageConvTime] - 1);
               end
            end
         end
         default: nxt_state = ST_HALT;
      endcase
      // Any write or write transfer restarts from a clean halt, dropping partial sums.
      // Settings are read again from the register when the halt ends.
      if (wrBusy || cfgWrite) begin
         nxt_state = ST_HALT;                                                     // R9
         nxt_set   = '0;
      end
   end

   // ==========================================================
   // Registers; a full-reset write acts exactly like the reset input.
   // The full-reset bit itself is never stored, so it always reads back as zero and
   // the reset lasts one cycle without any further host action.
   always_ff @(posedge core_clk) begin
      if (rst || softReset) begin                                                 // R1
         cfg_ff   <= cfg_t'(CFG_RESET);                                           // R6
         cur_ff   <= CUR_RESET;                                                   // R7
         rd_ff    <= RD_UNMAPPED;
         state_ff <= ST_HALT;
         timer_ff <= '0;
         set_ff   <= '0;
      end else begin
         cfg_ff   <= nxt_cfg;
         cur_ff   <= nxt_cur;
         rd_ff    <= nxt_rd;
         state_ff <= nxt_state;
         timer_ff <= nxt_timer;
         set_ff   <= nxt_set;
      end
   end

   // Averaging of current samples.
   // The averager shares the soft reset and is cleared by every write, so a new set
   // never mixes samples taken under the old settings.
   sample_averager #(
      .DATA_W   (16),
      .MAX_LOG2 (AVG_MAX_LOG2)
   ) u_avg (
      .core_clk    (core_clk),
      .rst         (rst || softReset),
      .clear       (avgClear),
      .log2Count   (AVG_LOG2[cfg_ff.sampleAverageCount]),
      .sampleValid (curSampleValid),
      .sample      (shuntSample),
      .resultValid (avgValid),
      .result      (avgResult)
   );

   // Status outputs decoded from the state register; power-down is decoded from the mode field.
   // Both conversion states have the upper code bit set, so measuring is a single bit
   // of the state register and cannot glitch.
   assign regRdData        = rd_ff;
   assign measuring        = state_ff[1];
   assign measuringCurrent = (state_ff == ST_CONVCUR);
   assign poweredDown      = modeOff;
endmodule

/* File: verilog/monitor_pkg.sv */
// Shared constants and types for the monitor measurement and configuration block.
// Assumes a single 50 MHz core clock and a pointer-addressed register port.
package monitor_pkg;

   // ==========================================================
   // Register pointers and reset values.
   localparam logic [7:0]  CFG_ADDR      = 8'h00;
   localparam logic [7:0]  CUR_ADDR      = 8'h01;
   localparam logic [15:0] CFG_RESET     = 16'h6127;
   localparam logic [15:0] CUR_RESET     = 16'h0000;
   localparam logic [15:0] RD_UNMAPPED   = 16'h0000;
   localparam logic [2:0]  CFG_FIXED     = 3'h6;

   // ==========================================================
   // Field layout of the configuration register, bit 15 down to bit 0.
   typedef struct packed {
      logic       fullReset;
      logic [2:0] fixedBits;
      logic [2:0] sampleAverageCount;
      logic [2:0] busVoltageConvTime;
      logic [2:0] shuntCurrentConvTime;
      logic [2:0] opMode;
   } cfg_t;

   // Register port request, one transfer per cycle.
   typedef struct packed {
      logic        wrEn;
      logic        rdEn;
      logic [7:0]  addr;
      logic [15:0] wrData;
   } reg_req_t;

   // ==========================================================
   // Operating mode decode: bit 2 selects continuous, bits 1..0 select what is measured.
   localparam int unsigned MODE_CONT_BIT = 2;
   localparam int unsigned MODE_BUS_BIT  = 1;
   localparam int unsigned MODE_CUR_BIT  = 0;

   // Averaging codes map to log2 of the sample count: 1,4,16,64,128,256,512,1024.
   localparam int unsigned AVG_MAX_LOG2 = 10;
   localparam logic [3:0] AVG_LOG2 [8] = '{4'h0, 4'h2, 4'h4, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha};

   // ==========================================================
   // Conversion times in nanoseconds and their cycle counts at the core clock.
   localparam int unsigned CLK_PERIOD_NS = 20;
   localparam int unsigned CONV_TIME_NS [8] = '{140000, 204000, 332000, 588000,
                                                1100000, 2116000, 4156000, 8244000};
   localparam int unsigned CONV_CYCLES_DEF [8] = '{
      CONV_TIME_NS[0] / CLK_PERIOD_NS, CONV_TIME_NS[1] / CLK_PERIOD_NS,
      CONV_TIME_NS[2] / CLK_PERIOD_NS, CONV_TIME_NS[3] / CLK_PERIOD_NS,
      CONV_TIME_NS[4] / CLK_PERIOD_NS, CONV_TIME_NS[5] / CLK_PERIOD_NS,
      CONV_TIME_NS[6] / CLK_PERIOD_NS, CONV_TIME_NS[7] / CLK_PERIOD_NS};
   localparam int unsigned TIMER_W = 20;

   // Sequencer states.
   typedef enum logic [1:0] {
      ST_HALT    = 2'b00,
      ST_IDLE    = 2'b01,
      ST_CONVCUR = 2'b10,
      ST_CONVBUS = 2'b11
   } seq_state_t;

endpackage

/* File: verilog/sample_averager.sv */
// Running sum of signed current samples; emits the mean after 2**log2Count samples.
// Assumes samples come from logic on the same clock, one valid pulse per sample.
module sample_averager #(
   parameter int unsigned DATA_W   = 16,
   parameter int unsigned MAX_LOG2 = 10
) (
   input  wire logic                     core_clk,
   input  wire logic                     rst,
   input  wire logic                     clear,
   input  wire logic [3:0]               log2Count,
   input  wire logic                     sampleValid,
   input  wire logic signed [DATA_W-1:0] sample,
   output logic                          resultValid,
   output logic signed [DATA_W-1:0]      result
);
   localparam int unsigned ACC_W = DATA_W + MAX_LOG2;

   logic signed [ACC_W-1:0]  acc_ff,   nxt_acc;
   logic [MAX_LOG2:0]        cnt_ff,   nxt_cnt;
   logic                     valid_ff, nxt_valid;
   logic signed [DATA_W-1:0] res_ff,   nxt_res;
   logic signed [ACC_W-1:0]  sum;
   logic [MAX_LOG2:0]        last;

   // ==========================================================
   // Accumulate; on the last sample of a set the shifted sum is the mean.
   // A shift instead of a divider works because every count is a power of two.
   always_comb begin
      sum       = acc_ff + ACC_W'(sample);
      last      = (MAX_LOG2+1)'((1 << log2Count) - 1);
      nxt_acc   = acc_ff;
      nxt_cnt   = cnt_ff;
      nxt_valid = 1'b0;
      nxt_res   = res_ff;
      if (clear) begin
         nxt_acc = '0;
         nxt_cnt = '0;
      end else if (sampleValid) begin
         if (cnt_ff == last) begin
            nxt_res   = DATA_W'(sum >>> log2Count); // R8
            nxt_valid = 1'b1;
            nxt_acc   = '0;
            nxt_cnt   = '0;
         end else begin
            nxt_acc = sum;
            nxt_cnt = cnt_ff + 1'b1;
         end
      end
   end

   // Registers only.
   always_ff @(posedge core_clk) begin
      if (rst) begin
         acc_ff   <= '0;
         cnt_ff   <= '0;
         valid_ff <= 1'b0;
         res_ff   <= '0;
      end else begin
         acc_ff   <= nxt_acc;
         cnt_ff   <= nxt_cnt;
         valid_ff <= nxt_valid;
         res_ff   <= nxt_res;
      end
   end

   assign resultValid = valid_ff;
   assign result      = res_ff;
endmodule
